/* File: rtl/crsi_entry_sweep.sv */
// Sweeps an index over cache and translation entries, producing one invalidate strobe per entry.
`timescale 1ns/1ps
module crsi_entry_sweep
  import crsi_pkg::*;
#(
  parameter int unsigned ENTRIES = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  output logic inval_out,
  output logic [$clog2(ENTRIES)-1:0] index_out,
  output logic done_out
);
  localparam int unsigned IW = $clog2(ENTRIES);
  localparam logic [IW-1:0] LAST = IW'(ENTRIES - 1);
  logic busy_q;
  logic [IW-1:0] idx_q;
  logic done_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_q <= 1'b0;
      idx_q <= '0;
      done_q <= 1'b0;
    end else if (ce_in) begin
      if (start_in) begin
        busy_q <= 1'b1;
        idx_q <= '0;
        done_q <= 1'b0;
      end else if (busy_q) begin
        if (idx_q == LAST) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          idx_q <= idx_q + 1'b1;
        end
      end
    end
  end

  assign inval_out = busy_q;
  assign index_out = idx_q;
  assign done_out = done_q;
endmodule : crsi_entry_sweep

/* File: rtl/crsi_pkg.sv */
// Package of reset values, field widths and sequencer timing for the reset state initialiser.
package crsi_pkg;
  localparam int unsigned CRSI_W = 32;
  localparam logic [31:0] CRSI_FLAGS_RST = 32'h0000_0002;
  localparam int unsigned CRSI_FLAGS_UNDEF_BITS = 10;
  localparam logic [31:0] CRSI_IP_RST = 32'h0000_FF00;
  localparam logic [31:0] CRSI_CR0_RST = 32'h6000_0010;
  localparam logic [31:0] CRSI_ZERO = 32'h0000_0000;
  localparam logic [15:0] CRSI_CS_SEL_RST = 16'hF000;
  localparam logic [31:0] CRSI_CS_BASE_RST = 32'h000F_F000;
  localparam logic [15:0] CRSI_SEG_SEL_RST = 16'h0000;
  localparam logic [31:0] CRSI_SEG_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] CRSI_SEG_LIMIT_RST = 32'h0000_FFFF;
  localparam logic [31:0] CRSI_SEG_AR_RST = 32'h0000_0093;
  localparam logic [31:0] CRSI_DTR_LIMIT_RST = 32'h0000_FFFF;
  localparam logic [31:0] CRSI_DTR_AR_RST = 32'h0000_0082;
  localparam logic [31:0] CRSI_DR6_RST = 32'hFFFF_0FF0;
  localparam logic [31:0] CRSI_DR7_RST = 32'h0000_0400;
  localparam int unsigned CRSI_NUM_DSEG = 5;
  localparam int unsigned CRSI_NUM_GEN = 6;
  localparam int unsigned CRSI_NUM_DBG = 4;
  localparam int unsigned CRSI_CACHE_LINES = 16;
  localparam int unsigned CRSI_TLB_ENTRIES = 8;
  localparam int unsigned CRSI_TSC_W = 64;
  localparam int unsigned CRSI_SELFTEST_CYC = 16;
  typedef enum logic [2:0] {
    CRSI_ST_RESET = 3'b000,
    CRSI_ST_CLEAR = 3'b001,
    CRSI_ST_SELFTEST = 3'b010,
    CRSI_ST_RUN = 3'b011,
    CRSI_ST_DRAIN = 3'b100
  } crsi_state_t;
endpackage : crsi_pkg

/* File: rtl/crsi_reset_state.sv */
// Integer unit reset state loader with self test result reporting and serialization drain.
`timescale 1ns/1ps
module crsi_reset_state
  import crsi_pkg::*;
#(
  parameter logic [31:0] SIGNATURE = 32'h0000_0A5C, // Arbitrary value, not a real part identifier.
  parameter int unsigned CACHE_LINES = CRSI_CACHE_LINES,
  parameter int unsigned TLB_ENTRIES = CRSI_TLB_ENTRIES,
  parameter int unsigned SELFTEST_CYC = CRSI_SELFTEST_CYC
) (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic HW_RESET_PIN_IN,
  input wire logic BUILT_IN_SELF_TEST_IN,
  input wire logic SELFTEST_FAIL_IN,
  input wire logic SERIALIZE_IN,
  input wire logic [7:0] PENDING_OPS_IN,
  input wire logic COMMIT_IN,
  output logic [31:0] PROCESSOR_FLAGS_REG_OUT,
  output logic [31:0] IP_OUT,
  output logic [15:0] CS_SEL_OUT,
  output logic [31:0] CS_BASE_OUT,
  output logic [31:0] CR0_OUT,
  output logic [31:0] CR2_OUT,
  output logic [31:0] CR3_OUT,
  output logic [31:0] CR4_OUT,
  output logic [16*CRSI_NUM_DSEG-1:0] DATA_STACK_SEGMENT_REGS_SEL_OUT,
  output logic [32*CRSI_NUM_DSEG-1:0] DATA_STACK_SEGMENT_REGS_BASE_OUT,
  output logic [32*CRSI_NUM_DSEG-1:0] DATA_STACK_SEGMENT_REGS_LIMIT_OUT,
  output logic [32*CRSI_NUM_DSEG-1:0] DATA_STACK_SEGMENT_REGS_AR_OUT,
  output logic [31:0] DATA_REG_SIGNATURE_OUT,
  output logic [31:0] ACCUM_OUT,
  output logic [32*CRSI_NUM_GEN-1:0] GEN_REGS_OUT,
  output logic [31:0] DTR_LIMIT_OUT,
  output logic [31:0] DTR_AR_OUT,
  output logic [32*CRSI_NUM_DBG-1:0] DBG_ADDR_OUT,
  output logic [31:0] DBG_STATUS_OUT,
  output logic [31:0] DBG_CTRL_OUT,
  output logic [CRSI_TSC_W-1:0] TSC_OUT,
  output logic [CACHE_LINES-1:0] CACHE_VALID_OUT,
  output logic [TLB_ENTRIES-1:0] TLB_VALID_OUT,
  output logic RANGES_ENABLE_OUT,
  output logic LOCAL_IRQ_CTRL_ENABLE_OUT,
  output logic FETCH_ENABLE_OUT,
  output logic EXEC_STALL_OUT,
  output logic INIT_DONE_OUT
);
  // ==========================================================================
  // Sequencer
  // ==========================================================================
  crsi_state_t state_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic built_in_self_test_s1_q;
  logic built_in_self_test_s2_q;
  logic built_in_self_test_req_q;
  logic fail_seen_q;
  logic [$clog2(SELFTEST_CYC+1)-1:0] st_cnt_q;
  logic cache_done;
  logic tlb_done;
  logic cache_inval;
  logic tlb_inval;
  logic [$clog2(CACHE_LINES)-1:0] cache_idx;
  logic [$clog2(TLB_ENTRIES)-1:0] tlb_idx;
  logic sweep_start;
  logic in_reset;
  localparam logic [$clog2(SELFTEST_CYC+1)-1:0] ST_LAST = ($clog2(SELFTEST_CYC+1))'(SELFTEST_CYC - 1);

  // The reset pin is asynchronous to this clock, so it is synchronised before use.
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      built_in_self_test_s1_q <= 1'b0;
      built_in_self_test_s2_q <= 1'b0;
    end else if (CE_IN) begin
      pin_s1_q <= HW_RESET_PIN_IN;
      pin_s2_q <= pin_s1_q;
      built_in_self_test_s1_q <= BUILT_IN_SELF_TEST_IN;
      built_in_self_test_s2_q <= built_in_self_test_s1_q;
    end
  end

  assign in_reset = RST_IN || pin_s2_q;
  assign sweep_start = (state_q == CRSI_ST_RESET) && !pin_s2_q;

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      state_q <= CRSI_ST_RESET;
      built_in_self_test_req_q <= 1'b0;
      st_cnt_q <= '0;
      fail_seen_q <= 1'b0;
    end else if (CE_IN) begin
      if (pin_s2_q) begin
        state_q <= CRSI_ST_RESET;
        built_in_self_test_req_q <= built_in_self_test_s2_q;
        st_cnt_q <= '0;
        fail_seen_q <= 1'b0;
      end else begin
        case (state_q)
          CRSI_ST_RESET: state_q <= CRSI_ST_CLEAR;
          CRSI_ST_CLEAR: begin
            if (cache_done && tlb_done) begin
              state_q <= built_in_self_test_req_q ? CRSI_ST_SELFTEST : CRSI_ST_RUN;
            end
          end
          CRSI_ST_SELFTEST: begin
            fail_seen_q <= fail_seen_q | SELFTEST_FAIL_IN;
            st_cnt_q <= st_cnt_q + 1'b1;
            if (st_cnt_q == ST_LAST) begin
              state_q <= CRSI_ST_RUN;
            end
          end
          CRSI_ST_RUN: begin
            if (SERIALIZE_IN) begin
              state_q <= CRSI_ST_DRAIN;
            end
          end
          CRSI_ST_DRAIN: begin
            if (PENDING_OPS_IN == 8'h00) begin
              state_q <= CRSI_ST_RUN;
            end
          end
          default: state_q <= CRSI_ST_RESET;
        endcase
      end
    end
  end

  crsi_entry_sweep #(.ENTRIES(CACHE_LINES)) u_cache_sweep (
    .clk_in(CLOCK_IN),
    .rst_in(in_reset),
    .ce_in(CE_IN),
    .start_in(sweep_start),
    .inval_out(cache_inval),
    .index_out(cache_idx),
    .done_out(cache_done)
  );

  crsi_entry_sweep #(.ENTRIES(TLB_ENTRIES)) u_tlb_sweep (
    .clk_in(CLOCK_IN),
    .rst_in(in_reset),
    .ce_in(CE_IN),
    .start_in(sweep_start),
    .inval_out(tlb_inval),
    .index_out(tlb_idx),
    .done_out(tlb_done)
  );

  // ==========================================================================
  // Architectural registers
  // ==========================================================================
  // Values are the same with or without the self test; only the accumulator differs.
  always_ff @(posedge CLOCK_IN) begin
    if (in_reset) begin
      PROCESSOR_FLAGS_REG_OUT <= CRSI_FLAGS_RST;
      IP_OUT <= CRSI_IP_RST;
      CS_SEL_OUT <= CRSI_CS_SEL_RST;
      CS_BASE_OUT <= CRSI_CS_BASE_RST;
      CR0_OUT <= CRSI_CR0_RST;
      CR2_OUT <= CRSI_ZERO;
      CR3_OUT <= CRSI_ZERO;
      CR4_OUT <= CRSI_ZERO;
      DATA_REG_SIGNATURE_OUT <= SIGNATURE;
      GEN_REGS_OUT <= '0;
      DTR_LIMIT_OUT <= CRSI_DTR_LIMIT_RST;
      DTR_AR_OUT <= CRSI_DTR_AR_RST;
      DBG_ADDR_OUT <= '0;
      DBG_STATUS_OUT <= CRSI_DR6_RST;
      DBG_CTRL_OUT <= CRSI_DR7_RST;
      RANGES_ENABLE_OUT <= 1'b0;
      LOCAL_IRQ_CTRL_ENABLE_OUT <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CRSI_NUM_DSEG; g++) begin : g_dseg
      always_ff @(posedge CLOCK_IN) begin
        if (in_reset) begin
          DATA_STACK_SEGMENT_REGS_SEL_OUT[16*g +: 16] <= CRSI_SEG_SEL_RST;
          DATA_STACK_SEGMENT_REGS_BASE_OUT[32*g +: 32] <= CRSI_SEG_BASE_RST;
          DATA_STACK_SEGMENT_REGS_LIMIT_OUT[32*g +: 32] <= CRSI_SEG_LIMIT_RST;
          DATA_STACK_SEGMENT_REGS_AR_OUT[32*g +: 32] <= CRSI_SEG_AR_RST;
        end
      end
    end
  endgenerate

  // Self test outcome: zero only if no failure was seen during the test window.
  always_ff @(posedge CLOCK_IN) begin
    if (in_reset) begin
      ACCUM_OUT <= CRSI_ZERO;
    end else if (CE_IN && state_q == CRSI_ST_SELFTEST && st_cnt_q == ST_LAST) begin
      ACCUM_OUT <= (fail_seen_q || SELFTEST_FAIL_IN) ? 32'h0000_0001 : CRSI_ZERO;
    end
  end

  // Time stamp counter runs once instructions may be fetched.
  always_ff @(posedge CLOCK_IN) begin
    if (in_reset) begin
      TSC_OUT <= '0;
    end else if (CE_IN && FETCH_ENABLE_OUT) begin
      TSC_OUT <= TSC_OUT + 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      CACHE_VALID_OUT <= '0;
      TLB_VALID_OUT <= '0;
    end else if (CE_IN) begin
      if (cache_inval) begin
        CACHE_VALID_OUT[cache_idx] <= 1'b0;
      end
      if (tlb_inval) begin
        TLB_VALID_OUT[tlb_idx] <= 1'b0;
      end
    end
  end

  // Fetch waits until every register has been loaded and entries are invalid.
  assign FETCH_ENABLE_OUT = (state_q == CRSI_ST_RUN) || (state_q == CRSI_ST_DRAIN);
  // Stall covers the serialize cycle itself so nothing younger issues before the drain.
  assign EXEC_STALL_OUT = (state_q == CRSI_ST_DRAIN) || (state_q == CRSI_ST_RUN && SERIALIZE_IN) || !FETCH_ENABLE_OUT;
  assign INIT_DONE_OUT = FETCH_ENABLE_OUT;
  logic unused_commit;
  assign unused_commit = COMMIT_IN;
endmodule : crsi_reset_state

/* File: tb/crsi_reset_state_monitor.sv */
// Checker for reset values and serialization stall of the reset state initialiser.
`timescale 1ns/1ps
module crsi_reset_state_monitor
  import crsi_pkg::*;
#(
  parameter logic [31:0] SIGNATURE = 32'h0000_0A5C
) (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic SERIALIZE_IN,
  input wire logic [7:0] PENDING_OPS_IN,
  input wire logic [31:0] PROCESSOR_FLAGS_REG_OUT,
  input wire logic [31:0] IP_OUT,
  input wire logic [31:0] CR0_OUT,
  input wire logic [32*CRSI_NUM_DSEG-1:0] DATA_STACK_SEGMENT_REGS_AR_OUT,
  input wire logic [31:0] DATA_REG_SIGNATURE_OUT,
  input wire logic [31:0] ACCUM_OUT,
  input wire logic [32*CRSI_NUM_GEN-1:0] GEN_REGS_OUT,
  input wire logic FETCH_ENABLE_OUT,
  input wire logic EXEC_STALL_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // ====
  // Reset values
  // The top ten flag bits are left out because they may read either way.
  a_core_reset: assert property ($fell(RST_IN) |-> PROCESSOR_FLAGS_REG_OUT[21:0] == CRSI_FLAGS_RST[21:0]
    && IP_OUT == CRSI_IP_RST && CR0_OUT == CRSI_CR0_RST) else $error("core reset values wrong");
  a_seg_reset: assert property ($fell(RST_IN) |-> DATA_STACK_SEGMENT_REGS_AR_OUT == {5{CRSI_SEG_AR_RST}})
    else $error("segment rights wrong after reset");
  a_sig_gen_reset: assert property ($fell(RST_IN) |-> DATA_REG_SIGNATURE_OUT == SIGNATURE && GEN_REGS_OUT == '0)
    else $error("signature or general registers wrong");
  a_no_early_fetch: assert property ($fell(RST_IN) |-> !FETCH_ENABLE_OUT [*8]) else $error("fetch too early");
  a_init_bound: assert property ($fell(RST_IN) |-> ##[1:60] FETCH_ENABLE_OUT) else $error("fetch never enabled");
  a_accum_hold: assert property (FETCH_ENABLE_OUT && $past(FETCH_ENABLE_OUT) |-> $stable(ACCUM_OUT))
    else $error("accumulator changed while running");
  // ====
  // Serialization
  // Stall is also high through the whole start-up, so only a stall while fetch is enabled counts as a drain.
  sequence s_draining;
    (FETCH_ENABLE_OUT && EXEC_STALL_OUT) ##1 (FETCH_ENABLE_OUT && EXEC_STALL_OUT && PENDING_OPS_IN == 8'h00 && CE_IN);
  endsequence
  a_stall_on_ser: assert property (FETCH_ENABLE_OUT && SERIALIZE_IN && CE_IN |-> EXEC_STALL_OUT)
    else $error("serialize did not stall");
  a_stall_holds: assert property (EXEC_STALL_OUT && PENDING_OPS_IN != 8'h00 |=> EXEC_STALL_OUT)
    else $error("stall dropped with work pending");
  a_drain_ends: assert property (s_draining |=> FETCH_ENABLE_OUT && (!EXEC_STALL_OUT || SERIALIZE_IN))
    else $error("drain did not end");
endmodule : crsi_reset_state_monitor

bind crsi_reset_state crsi_reset_state_monitor #(.SIGNATURE(SIGNATURE)) i_mon (.CLOCK_IN(CLOCK_IN),
  .RST_IN(RST_IN), .CE_IN(CE_IN), .SERIALIZE_IN(SERIALIZE_IN), .PENDING_OPS_IN(PENDING_OPS_IN),
  .PROCESSOR_FLAGS_REG_OUT(PROCESSOR_FLAGS_REG_OUT), .IP_OUT(IP_OUT), .CR0_OUT(CR0_OUT),
  .DATA_STACK_SEGMENT_REGS_AR_OUT(DATA_STACK_SEGMENT_REGS_AR_OUT), .DATA_REG_SIGNATURE_OUT(DATA_REG_SIGNATURE_OUT),
  .ACCUM_OUT(ACCUM_OUT), .GEN_REGS_OUT(GEN_REGS_OUT), .FETCH_ENABLE_OUT(FETCH_ENABLE_OUT),
  .EXEC_STALL_OUT(EXEC_STALL_OUT));

/* File: tb/tb.sv */
// Self-checking bench for the reset state initialiser.
`timescale 1ns/1ps
module tb;
  import crsi_pkg::*;
  localparam logic [31:0] SIG = 32'h0000_0A5C; // Arbitrary value, not a part identifier.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic pin = 1'b0;
  logic built_in_self_test = 1'b0;
  logic fail = 1'b0;
  logic ser = 1'b0;
  logic [7:0] pend = 8'h00;
  logic [31:0] flags, ip, cr0, cr2, cr3, cr4, cs_base, sig, acc, dlim_t, dar_t, dstat, dctl;
  logic [15:0] cs_sel;
  logic [79:0] dsel;
  logic [159:0] dbase, dlim, dar;
  logic [191:0] gen;
  logic [127:0] daddr;
  logic [15:0] cval;
  logic [7:0] tval;
  logic rng, lapic, fetch, stall;
  logic [63:0] tsc;
  logic done;
  int bad_count = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  crsi_reset_state #(.SIGNATURE(SIG), .SELFTEST_CYC(4)) i_dut (.CLOCK_IN(clk), .RST_IN(rst), .CE_IN(ce),
    .HW_RESET_PIN_IN(pin), .BUILT_IN_SELF_TEST_IN(built_in_self_test), .SELFTEST_FAIL_IN(fail), .SERIALIZE_IN(ser),
    .PENDING_OPS_IN(pend), .COMMIT_IN(1'b0), .PROCESSOR_FLAGS_REG_OUT(flags), .IP_OUT(ip), .CS_SEL_OUT(cs_sel),
    .CS_BASE_OUT(cs_base), .CR0_OUT(cr0), .CR2_OUT(cr2), .CR3_OUT(cr3), .CR4_OUT(cr4),
    .DATA_STACK_SEGMENT_REGS_SEL_OUT(dsel), .DATA_STACK_SEGMENT_REGS_BASE_OUT(dbase),
    .DATA_STACK_SEGMENT_REGS_LIMIT_OUT(dlim), .DATA_STACK_SEGMENT_REGS_AR_OUT(dar), .DATA_REG_SIGNATURE_OUT(sig),
    .ACCUM_OUT(acc), .GEN_REGS_OUT(gen), .DTR_LIMIT_OUT(dlim_t), .DTR_AR_OUT(dar_t), .DBG_ADDR_OUT(daddr),
    .DBG_STATUS_OUT(dstat), .DBG_CTRL_OUT(dctl), .TSC_OUT(tsc), .CACHE_VALID_OUT(cval), .TLB_VALID_OUT(tval),
    .RANGES_ENABLE_OUT(rng), .LOCAL_IRQ_CTRL_ENABLE_OUT(lapic), .FETCH_ENABLE_OUT(fetch),
    .EXEC_STALL_OUT(stall), .INIT_DONE_OUT(done));
  // ====
  // Helpers
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_fetch();
    int n;
    n = 0;
    while (fetch !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(fetch, 1'b1);
    chk(done, 1'b1);
  endtask : wait_fetch
  task automatic check_state(input logic failed);
    chk(flags[21:0], CRSI_FLAGS_RST[21:0]);
    chk({ip, cr0, cr2, cr3, cr4, cs_sel, cs_base}, {CRSI_IP_RST, CRSI_CR0_RST, 96'h0, CRSI_CS_SEL_RST, CRSI_CS_BASE_RST});
    chk({dsel, dbase}, '0);
    chk(dlim, {5{CRSI_SEG_LIMIT_RST}});
    chk(dar, {5{CRSI_SEG_AR_RST}});
    chk({sig, cval, tval, daddr}, {SIG, 152'h0});
    chk(gen, '0);
    chk(tsc, '0);
    chk({dlim_t, dar_t, dstat, dctl, rng, lapic}, {CRSI_DTR_LIMIT_RST, CRSI_DTR_AR_RST, CRSI_DR6_RST, CRSI_DR7_RST, 2'b01});
    chk(acc != 32'h0000_0000, failed);
  endtask : check_state
  // The self test request is only seen during a pin reset, so the pin drives those runs.
  task automatic pin_reset(input logic b, input logic f);
    @(posedge clk);
    pin <= 1'b1;
    built_in_self_test <= b;
    fail <= f;
    repeat (4) @(posedge clk);
    pin <= 1'b0;
    #1;
    chk(fetch, 1'b0);
    wait_fetch();
    check_state(f);
    built_in_self_test <= 1'b0;
    fail <= 1'b0;
  endtask : pin_reset
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // ====
  // Tests
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    ser <= 1'b1;
    @(posedge clk);
    ser <= 1'b0;
    wait_fetch();
    chk(stall, 1'b0);
    check_state(1'b0);
    @(posedge clk);
    pend <= 8'h03;
    ser <= 1'b1;
    @(posedge clk);
    ser <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(stall, 1'b1);
    @(posedge clk);
    ce <= 1'b0;
    pend <= 8'h00;
    repeat (3) @(posedge clk);
    #1;
    chk(stall, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({stall, fetch}, 2'b01);
    pin_reset(1'b1, 1'b0);
    pin_reset(1'b1, 1'b1);
    pin_reset(1'b0, 1'b0);
    final_report();
  end
  initial begin
    #10000;
    bad_count++;
    final_report();
  end
endmodule : tb
